// ---- rtl/sppc_top.sv ----
// Serial port pin configuration: APB registers, pin function mux, mode fault
// Overview of operation
// - Master-in pin direction per role and bit
// - Master-out pin direction per role and bit
// - Clock pin follows role, ignores direction bit
// - Master, select bit clear: low raises fault
// - Slave, bit clear: first select is input
// - Other selects: master per bit, slave inactive
// - Receive pin always input to async unit
// - Clock pin is GPIO until sync enable
// - Transmit pin is GPIO until tx enable
// - Transmit enable forces pin to output
// - Control 0 host read-write, unit read-only
// - Master select: 0 slave, 1 master
// - Open-drain select: 0 push-pull, 1 open-drain
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module sppc_top (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Sync unit side
	input  wire logic        sync_mosi_out,
	input  wire logic        sync_miso_out,
	input  wire logic        sync_sck_out,
	input  wire logic [3:0]  sync_sel_out,
	output logic             sync_data_in,
	output logic             sync_sck_in,
	output logic             sync_ss_in,
	// Async unit side
	input  wire logic        async_tx_out,
	output logic             async_rx_in,
	// Control 0 fields seen by the sync unit, read only
	output logic [15:0]      ctrl0_view,
	// Port pins: input, output, output enable
	input  wire logic [7:0]  pin_i,
	output logic      [7:0]  pin_o,
	output logic      [7:0]  pin_oe,
	input  wire logic        rx_pin_i,
	// Interrupt
	output logic             irq
);
	import sppc_pkg::*;

	// Software state
	logic [15:0] ctrl0_q, ctrl0_d;         // Synchronous control register 0
	logic [7:0]  dir_q, dir_d;             // Port direction register
	logic [1:0]  en_q, en_d;               // Unit enables
	logic [1:0]  irq_en_q, irq_en_d;       // Interrupt enables
	logic [7:0]  gpio_q, gpio_d;           // GPIO output data
	logic [31:0] prdata_q, prdata_d;       // Registered read data
	logic [SPPC_NUM_EVENTS-1:0] clr;       // Clear strobes
	logic [SPPC_NUM_EVENTS-1:0] events;    // Event pulses
	logic [SPPC_NUM_EVENTS-1:0] status;    // Sticky flags
	logic        access;                   // APB access phase
	logic        wr, rd;
	logic        known;                    // Address is mapped
	logic        fault;                    // Mode fault pulse
	logic        role_q;                   // Previous role for change detect

	// Role and drive decoded from control 0
	logic master, odrain, sync_on, tx_on;
	logic [7:0] drv, lvl;                  // Wanted drive and level per pin

	// Zero wait state slave; unmapped addresses error
	assign access  = psel & penable;
	assign wr      = access & pwrite;
	assign rd      = access & ~pwrite;
	assign pready  = 1'b1;
	assign pslverr = access & ~known;

	// Address decode
	always_comb begin
		unique case (paddr)
			SPPC_OFF_CTRL0, SPPC_OFF_DIR, SPPC_OFF_ENABLES, SPPC_OFF_STATUS,
			SPPC_OFF_IRQ_EN, SPPC_OFF_CLEAR, SPPC_OFF_PINS, SPPC_OFF_GPIO: known = 1'b1;
			default: known = 1'b0;
		endcase
	end

	// Register writes: only the host writes control 0; the unit just reads it
	always_comb begin
		ctrl0_d  = ctrl0_q;
		dir_d    = dir_q;
		en_d     = en_q;
		irq_en_d = irq_en_q;
		gpio_d   = gpio_q;
		clr      = '0;
		if (wr) begin
			unique case (paddr)
				SPPC_OFF_CTRL0:   ctrl0_d  = pwdata[15:0];
				SPPC_OFF_DIR:     dir_d    = pwdata[7:0];
				SPPC_OFF_ENABLES: en_d     = pwdata[1:0];
				SPPC_OFF_IRQ_EN:  irq_en_d = pwdata[SPPC_NUM_EVENTS-1:0];
				SPPC_OFF_CLEAR:   clr      = pwdata[SPPC_NUM_EVENTS-1:0];
				SPPC_OFF_GPIO:    gpio_d   = pwdata[7:0];
				default: begin
					// Read-only or unmapped: ignored
				end
			endcase
		end
	end

	// Read mux into a register
	always_comb begin
		prdata_d = prdata_q;
		if (rd) begin
			unique case (paddr)
				SPPC_OFF_CTRL0:   prdata_d = {16'h0000, ctrl0_q};
				SPPC_OFF_DIR:     prdata_d = {24'h000000, dir_q};
				SPPC_OFF_ENABLES: prdata_d = {30'h0, en_q};
				SPPC_OFF_STATUS:  prdata_d = {30'h0, status};
				SPPC_OFF_IRQ_EN:  prdata_d = {30'h0, irq_en_q};
				SPPC_OFF_PINS:    prdata_d = {23'h0, rx_pin_i, pin_i};
				SPPC_OFF_GPIO:    prdata_d = {24'h000000, gpio_q};
				default:          prdata_d = 32'h00000000;
			endcase
		end
	end

	// Register all software state
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl0_q  <= SPPC_CTRL0_RESET;
			dir_q    <= SPPC_DIR_RESET;
			en_q     <= 2'h0;
			irq_en_q <= 2'h0;
			gpio_q   <= 8'h00;
			prdata_q <= 32'h00000000;
			role_q   <= 1'b0;
		end else begin
			ctrl0_q  <= ctrl0_d;
			dir_q    <= dir_d;
			en_q     <= en_d;
			irq_en_q <= irq_en_d;
			gpio_q   <= gpio_d;
			prdata_q <= prdata_d;
			role_q   <= master;
		end
	end

	// Read data appears during the access phase from the current read; otherwise the last read is held
	assign prdata     = rd ? prdata_d : prdata_q;
	assign ctrl0_view = ctrl0_q;

	// Control fields; software is expected to set these before enabling
	assign master  = ctrl0_q[SPPC_MASTER_SELECT_BIT_BIT];
	assign odrain  = ctrl0_q[SPPC_ODRAIN_BIT];
	assign sync_on = en_q[SPPC_EN_SYNC];
	assign tx_on   = en_q[SPPC_EN_TX];

	// Pin function mux: decide drive and level for each pin
	always_comb begin
		drv = '0;
		lvl = gpio_q;
		// Master-in pin
		if (master) begin
			drv[SPPC_PIN_MISO] = 1'b0;
		end else begin
			drv[SPPC_PIN_MISO] = dir_q[SPPC_DIR_MISO];
			lvl[SPPC_PIN_MISO] = sync_miso_out;
		end
		// Master-out pin
		if (master) begin
			drv[SPPC_PIN_MOSI] = dir_q[SPPC_DIR_MOSI];
			lvl[SPPC_PIN_MOSI] = sync_mosi_out;
		end else begin
			drv[SPPC_PIN_MOSI] = 1'b0;
		end
		// Clock pin: GPIO until the sync unit is enabled
		if (sync_on) begin
			drv[SPPC_PIN_SCK] = master;
			lvl[SPPC_PIN_SCK] = sync_sck_out;
		end else begin
			drv[SPPC_PIN_SCK] = dir_q[SPPC_DIR_SCK];
		end
		// First select: output only in master with bit set
		if (master && dir_q[SPPC_DIR_SEL0]) begin
			drv[SPPC_PIN_SEL0] = 1'b1;
			lvl[SPPC_PIN_SEL0] = sync_sel_out[0];
		end
		// Other selects: slave role leaves them inactive
		for (int i = 1; i < 4; i++) begin
			if (master) begin
				drv[SPPC_PIN_SEL0+i] = dir_q[SPPC_DIR_SEL0+i];
				lvl[SPPC_PIN_SEL0+i] = sync_sel_out[i];
			end else begin
				drv[SPPC_PIN_SEL0+i] = 1'b0;
			end
		end
		// Transmit pin: enable overrides the direction bit
		if (tx_on) begin
			drv[SPPC_PIN_TX] = 1'b1;
			lvl[SPPC_PIN_TX] = async_tx_out;
		end else begin
			drv[SPPC_PIN_TX] = dir_q[SPPC_DIR_TX];
		end
	end

	// Open-drain drives only low; the pin reads high via the pull-up
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_oe[i] = sppc_oe(drv[i], lvl[i], odrain);
			pin_o[i]  = odrain ? 1'b0 : lvl[i];
		end
	end

	// Inputs to the units; disabled inputs read idle
	assign sync_data_in = master ? (dir_q[SPPC_DIR_MISO] ? 1'b0 : pin_i[SPPC_PIN_MISO])
	                             : (dir_q[SPPC_DIR_MOSI] ? 1'b0 : pin_i[SPPC_PIN_MOSI]);
	assign sync_sck_in  = (sync_on && !master) ? pin_i[SPPC_PIN_SCK] : 1'b0;
	assign sync_ss_in   = (!master && !dir_q[SPPC_DIR_SEL0]) ? pin_i[SPPC_PIN_SEL0] : 1'b1;
	assign async_rx_in  = rx_pin_i;

	// Mode fault watcher, armed only in master role with the select as input
	sppc_modf #(
		.FILT    (SPPC_MODF_FILT)
	) u_modf (
		.clk_sys (clk_sys),
		.rst     (rst),
		.armed   (master & sync_on & ~dir_q[SPPC_DIR_SEL0]),
		.sel_in  (pin_i[SPPC_PIN_SEL0]),
		.fault   (fault)
	);

	// Events: mode fault and a role flip while the unit runs
	assign events[SPPC_ST_MODF]    = fault;
	assign events[SPPC_ST_ROLECHG] = sync_on & (role_q != master);

	// Status, enable and interrupt
	sppc_irq #(
		.N         (SPPC_NUM_EVENTS)
	) u_irq (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.event_in  (events),
		.clear_in  (clr),
		.enable_in (irq_en_q),
		.status    (status),
		.irq       (irq)
	);

	// Checks
	miso_master_a: assert property (@(posedge clk_sys) disable iff (rst)
		master |-> !pin_oe[SPPC_PIN_MISO])
		else $error("master-in driven in master role");
	mosi_slave_a: assert property (@(posedge clk_sys) disable iff (rst)
		!master |-> !pin_oe[SPPC_PIN_MOSI])
		else $error("master-out driven in slave role");
	sck_role_a: assert property (@(posedge clk_sys) disable iff (rst)
		(sync_on && !master) |-> !pin_oe[SPPC_PIN_SCK] && sync_sck_in == pin_i[SPPC_PIN_SCK])
		else $error("clock pin wrong in slave role");
	ss_slave_a: assert property (@(posedge clk_sys) disable iff (rst)
		(!master && !dir_q[SPPC_DIR_SEL0]) |-> sync_ss_in == pin_i[SPPC_PIN_SEL0])
		else $error("slave select not routed");
	sel_slave_a: assert property (@(posedge clk_sys) disable iff (rst)
		!master |-> pin_oe[6:4] == 3'b000)
		else $error("select driven in slave role");
	rx_route_a: assert property (@(posedge clk_sys) async_rx_in == rx_pin_i)
		else $error("receive pin not routed");
	sck_gpio_a: assert property (@(posedge clk_sys) disable iff (rst)
		(!sync_on && !odrain) |-> pin_oe[SPPC_PIN_SCK] == dir_q[SPPC_DIR_SCK])
		else $error("clock pin not gpio");
	tx_force_a: assert property (@(posedge clk_sys) disable iff (rst)
		(tx_on && !odrain) |-> pin_oe[SPPC_PIN_TX] && pin_o[SPPC_PIN_TX] == async_tx_out)
		else $error("transmit pin not forced out");
	ctrl_write_a: assert property (@(posedge clk_sys) disable iff (rst)
		(wr && paddr == SPPC_OFF_CTRL0) |=> ctrl0_q == $past(pwdata[15:0]))
		else $error("control write lost");
	odrain_low_a: assert property (@(posedge clk_sys) disable iff (rst)
		odrain |-> pin_o == 8'h00)
		else $error("open-drain drove high");
	modf_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
		fault |=> status[SPPC_ST_MODF])
		else $error("mode fault not flagged");

	// Routing and drive checks that the role tests above leave open
	miso_in_a: assert property (@(posedge clk_sys) disable iff (rst)
		(master && !dir_q[SPPC_DIR_MISO]) |-> sync_data_in == pin_i[SPPC_PIN_MISO])
		else $error("master-in not routed");
	sel0_out_a: assert property (@(posedge clk_sys) disable iff (rst)
		(master && dir_q[SPPC_DIR_SEL0] && !odrain)
		|-> pin_oe[SPPC_PIN_SEL0] && pin_o[SPPC_PIN_SEL0] == sync_sel_out[0])
		else $error("first select not driven");
	// Push-pull only: open-drain releases a high level
	tx_gpio_a: assert property (@(posedge clk_sys) disable iff (rst)
		(!tx_on && !odrain) |-> pin_oe[SPPC_PIN_TX] == dir_q[SPPC_DIR_TX])
		else $error("transmit pin not gpio");

	cov_master_c: cover property (@(posedge clk_sys) sync_on && master);
	cov_slave_c:  cover property (@(posedge clk_sys) sync_on && !master);
	cov_fault_c:  cover property (@(posedge clk_sys) fault);
	cov_irq_c:    cover property (@(posedge clk_sys) irq);

endmodule : sppc_top

// ---- rtl/sppc_pkg.sv ----
// Package of constants and types for the serial port pin configuration block
package sppc_pkg;

	// Register byte offsets on APB (word aligned)
	localparam logic [7:0]  SPPC_OFF_CTRL0   = 8'h00;   // Synchronous control register 0
	localparam logic [7:0]  SPPC_OFF_DIR     = 8'h04;   // Port direction register
	localparam logic [7:0]  SPPC_OFF_ENABLES = 8'h08;   // Unit enable bits
	localparam logic [7:0]  SPPC_OFF_STATUS  = 8'h0C;   // Sticky event status, read only
	localparam logic [7:0]  SPPC_OFF_IRQ_EN  = 8'h10;   // Interrupt enable
	localparam logic [7:0]  SPPC_OFF_CLEAR   = 8'h14;   // Write one to clear status
	localparam logic [7:0]  SPPC_OFF_PINS    = 8'h18;   // Live pin levels, read only
	localparam logic [7:0]  SPPC_OFF_GPIO    = 8'h1C;   // General purpose output data

	// Control register 0 layout and reset
	localparam logic [15:0] SPPC_CTRL0_RESET = 16'h0104;
	localparam int          SPPC_MASTER_SELECT_BIT_BIT    = 15;      // Master select
	localparam int          SPPC_ODRAIN_BIT  = 14;      // Open-drain select
	localparam int          SPPC_CLOCK_POLARITY_BIT_BIT    = 9;       // Clock polarity
	localparam int          SPPC_CLOCK_PHASE_BIT_BIT    = 8;       // Clock phase

	// Direction register bit positions
	localparam int          SPPC_DIR_MISO    = 0;
	localparam int          SPPC_DIR_MOSI    = 1;
	localparam int          SPPC_DIR_SCK     = 2;
	localparam int          SPPC_DIR_SEL0    = 3;
	localparam int          SPPC_DIR_TX      = 7;
	localparam logic [7:0]  SPPC_DIR_RESET   = 8'h00;

	// Enable register bit positions
	localparam int          SPPC_EN_SYNC     = 0;
	localparam int          SPPC_EN_TX       = 1;

	// Status bit positions
	localparam int          SPPC_ST_MODF     = 0;       // Mode fault
	localparam int          SPPC_ST_ROLECHG  = 1;       // Role changed while enabled
	localparam int          SPPC_NUM_EVENTS  = 2;

	// Pin index in an 8-bit port vector
	localparam int          SPPC_PIN_MISO    = 0;
	localparam int          SPPC_PIN_MOSI    = 1;
	localparam int          SPPC_PIN_SCK     = 2;
	localparam int          SPPC_PIN_SEL0    = 3;
	localparam int          SPPC_PIN_TX      = 7;

	// Slave-select sampling: number of low samples that confirm a fault
	localparam int          SPPC_MODF_FILT   = 2;

	// Pin enable decode: drive level to output enable honouring open-drain
	function automatic logic sppc_oe(input logic drive, input logic level, input logic odrain);
		sppc_oe = drive & (~odrain | ~level);
	endfunction : sppc_oe

endpackage : sppc_pkg

// ---- rtl/sppc_irq.sv ----
// Sticky event status, enable mask and interrupt output
`timescale 1ns/1ps
module sppc_irq #(
	parameter int N = 2
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst,
	// Events and software controls
	input  wire logic [N-1:0] event_in,
	input  wire logic [N-1:0] clear_in,
	input  wire logic [N-1:0] enable_in,
	// Results
	output logic      [N-1:0] status,
	output logic              irq
);
	import sppc_pkg::*;

	logic [N-1:0] status_q;   // Sticky flags
	logic [N-1:0] status_d;   // Next flags

	// Set wins over a clear in the same cycle
	always_comb begin
		status_d = (status_q & ~clear_in) | event_in;
	end

	// Register flags
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			status_q <= '0;
		end else begin
			status_q <= status_d;
		end
	end

	assign status = status_q;
	assign irq    = |(status_q & enable_in);

	set_wins_a: assert property (@(posedge clk_sys) disable iff (rst)
		(event_in != '0) |=> ((status_q & $past(event_in)) == $past(event_in)))
		else $error("event flag lost");

endmodule : sppc_irq

// ---- rtl/sppc_modf.sv ----
// Slave-select mode fault detector with a short glitch filter
`timescale 1ns/1ps
module sppc_modf #(
	parameter int FILT = 2
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// Qualifier and pin level
	input  wire logic armed,
	input  wire logic sel_in,
	// Fault pulse
	output logic      fault
);
	import sppc_pkg::*;

	logic [FILT-1:0] hist_q;   // Recent low samples
	logic [FILT-1:0] hist_d;
	logic            fault_q;  // Registered one-cycle pulse
	logic            fault_d;

	// Shift in low samples only while armed, so a role change clears history
	always_comb begin
		hist_d  = armed ? {hist_q[FILT-2:0], ~sel_in} : '0;
		fault_d = armed & (&hist_d) & ~(&hist_q);
	end

	// Register history and pulse
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			hist_q  <= '0;
			fault_q <= 1'b0;
		end else begin
			hist_q  <= hist_d;
			fault_q <= fault_d;
		end
	end

	assign fault = fault_q;

	fault_cause_a: assert property (@(posedge clk_sys) disable iff (rst)
		fault |-> $past(armed) && !$past(sel_in))
		else $error("fault without low select");

endmodule : sppc_modf

// ---- verification/sppc_peer.sv ----
// Far-side model: external serial peripherals on the port pins, with pull-ups
`timescale 1ns/1ps
module sppc_peer (
	// Device pin outputs
	input  wire logic [7:0] pin_o,
	input  wire logic [7:0] pin_oe,
	// Peripheral drive requests from the bench
	input  wire logic [7:0] ext_en,
	input  wire logic [7:0] ext_val,
	// Resolved wire levels
	output logic      [7:0] pin_i
);
	// Device wins while driving, then the peripheral; a released wire floats up
	// to the pull-up, so an open-drain high reads as the pull-up level unless a peripheral drives the wire
	always_comb begin
		for (int k = 0; k < 8; k++) begin
			pin_i[k] = pin_oe[k] ? pin_o[k] : (ext_en[k] ? ext_val[k] : 1'b1);
		end
	end
endmodule : sppc_peer

// ---- verification/testbench.sv ----
// Self-checking bench for the serial port pin configuration block
`timescale 1ns/1ps
module testbench;
	import sppc_pkg::*;
	// Clock, reset and APB
	logic        clk_sys = 1'b0;
	logic        rst     = 1'b1;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	// Unit sides
	logic        sync_mosi_out = 1'b1;
	logic        sync_miso_out = 1'b0;
	logic        sync_sck_out  = 1'b1;
	logic [3:0]  sync_sel_out  = 4'hA;
	logic        async_tx_out  = 1'b0;
	logic        rx_pin_i      = 1'b1;
	logic        sync_data_in, sync_sck_in, sync_ss_in, async_rx_in, irq;
	logic [15:0] ctrl0_view;
	// Pins and peripheral drive
	logic [7:0]  pin_i, pin_o, pin_oe;
	logic [7:0]  ext_en  = 8'h00;
	logic [7:0]  ext_val = 8'h00;
	// Results of the last transfer and bookkeeping
	logic [31:0] rd;
	logic        er;
	int          bad_count   = 0;
	int          checks_done = 0;
	int          cyc         = 0;

	sppc_top uut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.sync_mosi_out, .sync_miso_out, .sync_sck_out, .sync_sel_out, .sync_data_in, .sync_sck_in,
		.sync_ss_in, .async_tx_out, .async_rx_in, .ctrl0_view, .pin_i, .pin_o, .pin_oe, .rx_pin_i, .irq);
	sppc_peer peer (.pin_o, .pin_oe, .ext_en, .ext_val, .pin_i);

	// 100 MHz clock
	always #5 clk_sys = ~clk_sys;

	// Hang guard: the sequence needs well under a thousand cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc > 5000) begin
			bad_count++;
			complete_run();
		end
	end

	// Verdict and end of run
	task complete_run();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : complete_run

	// Compare seen against expected
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer; waits for pready, no fixed latency assumed
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// Let the registered results of this transfer settle before any compare
		@(negedge clk_sys);
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask : rdc

	// Single-bit compare once combinational outputs have settled
	task bchk(input logic s, input logic e);
		@(negedge clk_sys);
		check({31'h0, s}, {31'h0, e});
	endtask : bchk

	// Pin drive check; the level only matters while driven
	task pin(input int k, input logic oe, input logic o);
		bchk(pin_oe[k], oe);
		if (oe) bchk(pin_o[k], o);
	endtask : pin

	// Main sequence
	initial begin
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		rdc(SPPC_OFF_CTRL0, 32'h0000_0104);
		rdc(SPPC_OFF_DIR, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		check({31'h0, er}, 32'h1);  // Unmapped address refused
		wr(SPPC_OFF_CTRL0, 32'hFFFF_C3A5);
		rdc(SPPC_OFF_CTRL0, 32'h0000_C3A5);
		check({16'h0, ctrl0_view}, 32'h0000_C3A5);
		// Master role, loaded before enabling the unit
		wr(SPPC_OFF_CTRL0, 32'h8000);
		wr(SPPC_OFF_ENABLES, 32'h1);
		@(posedge clk_sys);
		ext_en  <= 8'h01;
		ext_val <= 8'h01;
		pin(0, 1'b0, 1'b0);
		bchk(sync_data_in, 1'b1);
		pin(1, 1'b0, 1'b0);
		pin(2, 1'b1, sync_sck_out);
		pin(4, 1'b0, 1'b0);
		wr(SPPC_OFF_DIR, 32'h7F);
		bchk(sync_data_in, 1'b0);
		pin(1, 1'b1, sync_mosi_out);
		pin(2, 1'b1, sync_sck_out);
		pin(3, 1'b1, sync_sel_out[0]);
		for (int k = 4; k < 7; k++) pin(k, 1'b1, sync_sel_out[k - 3]);
		// Slave role; unit disabled around the rewrite
		wr(SPPC_OFF_ENABLES, 32'h0);
		wr(SPPC_OFF_CTRL0, 32'h0);
		wr(SPPC_OFF_DIR, 32'h0);
		wr(SPPC_OFF_ENABLES, 32'h1);
		@(posedge clk_sys);
		ext_en  <= 8'h0E;
		ext_val <= 8'h06;
		@(negedge clk_sys);
		bchk(sync_data_in, 1'b1);
		bchk(sync_sck_in, 1'b1);
		bchk(sync_ss_in, 1'b0);
		pin(0, 1'b0, 1'b0);
		pin(2, 1'b0, 1'b0);
		wr(SPPC_OFF_DIR, 32'h7F);
		pin(0, 1'b1, sync_miso_out);
		bchk(sync_data_in, 1'b0);
		bchk(sync_ss_in, 1'b1);
		pin(2, 1'b0, 1'b0);
		for (int k = 4; k < 7; k++) pin(k, 1'b0, 1'b0);
		@(posedge clk_sys);
		ext_en <= 8'h00;
		// Port pins as plain outputs while units are off, then the clock pin driven by the sync unit
		wr(SPPC_OFF_ENABLES, 32'h0);
		wr(SPPC_OFF_GPIO, 32'h84);
		wr(SPPC_OFF_DIR, 32'h84);
		pin(2, 1'b1, 1'b1);
		pin(7, 1'b1, 1'b1);
		wr(SPPC_OFF_GPIO, 32'h0);
		pin(7, 1'b1, 1'b0);
		wr(SPPC_OFF_CTRL0, 32'h8000);
		wr(SPPC_OFF_ENABLES, 32'h1);
		@(posedge clk_sys);
		sync_sck_out <= 1'b0;
		pin(2, 1'b1, 1'b0);
		// Transmit pin forced to output once enabled
		wr(SPPC_OFF_DIR, 32'h0);
		pin(7, 1'b0, 1'b0);
		wr(SPPC_OFF_ENABLES, 32'h3);
		pin(7, 1'b1, 1'b0);
		@(posedge clk_sys);
		async_tx_out <= 1'b1;
		rx_pin_i     <= 1'b0;
		pin(7, 1'b1, 1'b1);
		bchk(async_rx_in, 1'b0);
		rdc(SPPC_OFF_PINS, {23'h0, 1'b0, pin_i});
		// Open-drain drive: low is pulled down, high is released
		wr(SPPC_OFF_ENABLES, 32'h0);
		wr(SPPC_OFF_CTRL0, 32'hC000);
		wr(SPPC_OFF_DIR, 32'h02);
		wr(SPPC_OFF_ENABLES, 32'h1);
		@(posedge clk_sys);
		sync_mosi_out <= 1'b0;
		@(negedge clk_sys);
		pin(1, 1'b1, 1'b0);
		@(posedge clk_sys);
		sync_mosi_out <= 1'b1;
		@(negedge clk_sys);
		bchk(pin_oe[1], 1'b0);
		bchk(pin_i[1], 1'b1);
		// Mode fault with interrupt enabled, then cleared
		wr(SPPC_OFF_ENABLES, 32'h0);
		wr(SPPC_OFF_CTRL0, 32'h8000);
		wr(SPPC_OFF_DIR, 32'h0);
		wr(SPPC_OFF_IRQ_EN, 32'h1);
		wr(SPPC_OFF_ENABLES, 32'h1);
		rdc(SPPC_OFF_STATUS, 32'h0);
		@(posedge clk_sys);
		ext_en  <= 8'h08;
		ext_val <= 8'h00;
		for (int n = 0; n < 10 && irq !== 1'b1; n++) @(posedge clk_sys);
		bchk(irq, 1'b1);
		@(posedge clk_sys);
		ext_en <= 8'h00;
		rdc(SPPC_OFF_STATUS, 32'h1);
		wr(SPPC_OFF_STATUS, 32'h0);
		rdc(SPPC_OFF_STATUS, 32'h1);
		wr(SPPC_OFF_CLEAR, 32'h1);
		rdc(SPPC_OFF_STATUS, 32'h0);
		bchk(irq, 1'b0);
		// Masked fault keeps the flag but not the interrupt
		wr(SPPC_OFF_IRQ_EN, 32'h0);
		@(posedge clk_sys);
		ext_en <= 8'h08;
		repeat (6) @(posedge clk_sys);
		ext_en <= 8'h00;
		rdc(SPPC_OFF_STATUS, 32'h1);
		bchk(irq, 1'b0);
		wr(SPPC_OFF_IRQ_EN, 32'h1);
		bchk(irq, 1'b1);
		wr(SPPC_OFF_CLEAR, 32'h1);
		// Slave role: a low select is no fault
		wr(SPPC_OFF_ENABLES, 32'h0);
		wr(SPPC_OFF_CTRL0, 32'h0);
		wr(SPPC_OFF_ENABLES, 32'h1);
		@(posedge clk_sys);
		ext_en <= 8'h08;
		repeat (6) @(posedge clk_sys);
		rdc(SPPC_OFF_STATUS, 32'h0);
		// Role rewritten while enabled: flagged, masked until its enable is set
		@(posedge clk_sys);
		ext_en <= 8'h00;
		wr(SPPC_OFF_CTRL0, 32'h8000);
		rdc(SPPC_OFF_STATUS, 32'h2);
		bchk(irq, 1'b0);
		wr(SPPC_OFF_IRQ_EN, 32'h3);
		bchk(irq, 1'b1);
		wr(SPPC_OFF_CLEAR, 32'h2);
		rdc(SPPC_OFF_STATUS, 32'h0);
		bchk(irq, 1'b0);
		complete_run();
	end
endmodule : testbench
